/* dv/lcal_core_model.sv */
`timescale 1ns/10ps
// ****************************************************************
// local bus core model
// ****************************************************************
module lcal_core_model
	import lcal_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        ack_i,
	input  wire logic        tea_i,
	output logic             req_o,
	output logic             wr_o,
	output logic      [31:0] addr_o,
	output logic      [1:0]  siz_o,
	output logic      [31:0] wdata_o
);
	initial begin
		req_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 32'h0;
		siz_o = 2'h0;
		wdata_o = 32'h0;
	end

	// one request cycle; idle address and data lines show the inverse so stale values never look valid
	task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] s,
		input logic [31:0] d, output logic [31:0] rd, output logic ak, output logic te);
		@(negedge clk_i);
		req_o = 1'b1;
		wr_o = w;
		addr_o = a;
		siz_o = s;
		wdata_o = d;
		// the answer is registered on the request edge; ack and error stand one cycle only,
		// so they are taken at the very next falling edge, before the lines drop
		@(negedge clk_i);
		rd = rdata_i;
		ak = ack_i;
		te = tea_i;
		req_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : xfer

	// partial update by read, merge and full-word write back
	task automatic rmw(input logic [31:0] a, input logic [1:0] k, input logic [7:0] b);
		logic [31:0] rd;
		logic        ak;
		logic        te;
		logic [31:0] m;
		xfer(1'b0, a, SIZ_WORD, 32'h0, rd, ak, te);
		m = 32'hff000000 >> (8 * k);
		xfer(1'b1, a, SIZ_WORD, (rd & ~m) | ({24'h0, b} << (8 * (3 - k))), rd, ak, te);
	endtask : rmw
endmodule : lcal_core_model

/* dv/lcal_local_ctrl_status_bank_tb_top.sv */
`timescale 1ns/10ps
module lcal_local_ctrl_status_bank_tb_top
	import lcal_pkg::*;
;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        sys_reset_i = 1'b0;
	logic        local_reset_i = 1'b0;
	logic        watchdog_i = 1'b0;
	logic [7:0]  status_i = 8'h00;
	logic [7:0]  event_i = 8'h00;
	logic [7:0]  action_done_i = 8'h00;
	logic        req, wr, ack, transfer_error_ack, lrst, ak, te;
	logic [31:0] addr, wdata, rdata, ctrl, rd;
	logic [1:0]  siz;
	logic [7:0]  flags, action;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cycles = 0;

	always #50 ref_clk_i = ~ref_clk_i;

	lcal_local_ctrl_status_bank lcal_local_ctrl_status_bank_i (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .sys_reset_i(sys_reset_i), .local_reset_i(local_reset_i),
		.watchdog_i(watchdog_i), .req_i(req), .wr_i(wr), .addr_i(addr), .siz_i(siz),
		.wdata_i(wdata), .status_i(status_i), .event_i(event_i),
		.action_done_i(action_done_i), .rdata_o(rdata), .ack_o(ack),
		.transfer_error_ack_o(transfer_error_ack), .ctrl_o(ctrl), .flags_o(flags), .action_o(action),
		.local_reset_o(lrst));

	lcal_core_model lcal_core_model_i (.clk_i(ref_clk_i), .rdata_i(rdata), .ack_i(ack),
		.tea_i(transfer_error_ack), .req_o(req), .wr_o(wr), .addr_o(addr), .siz_o(siz), .wdata_o(wdata));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s,
		input logic [31:0] d);
		lcal_core_model_i.xfer(w, a, s, d, rd, ak, te);
	endtask : acc

	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_map;
		acc(1'b0, BANK_BASE + OFF_CTRL, SIZ_WORD, 32'h0);
		check(32'(ak), 32'h1);
		check(32'(rd[23:0]), {8'h00, CTRL_L_RST, CTRL_S_RST, CTRL_P_RST});
		check(32'(flags), 32'(FLAG_RST));
		check(32'(action), 32'(ACT_RST));
		acc(1'b0, BANK_BASE + 32'h10, SIZ_WORD, 32'h0);
		check({rd[30:0], ak}, 32'h1);
		acc(1'b0, BANK_BASE + 32'h100, SIZ_WORD, 32'h0);
		check(32'({ak, te}), 32'h0);
		$display("test map done");
	endtask : t_map

	task automatic t_rw;
		acc(1'b1, BANK_BASE, SIZ_WORD, 32'ha55a3cc3);
		check(ctrl, 32'ha55a3cc3);
		acc(1'b0, BANK_BASE, SIZ_LINE, 32'h0);
		check(rd, 32'ha55a3cc3);
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, BANK_BASE + 32'(i), SIZ_BYTE, 32'h0);
			check(rd, 32'ha55a3cc3 & (32'hff000000 >> (8 * i)));
		end
		for (int i = 0; i < 2; i++) begin
			acc(1'b0, BANK_BASE + 32'(2 * i), SIZ_HALF, 32'h0);
			check(rd, 32'ha55a3cc3 & (32'hffff0000 >> (16 * i)));
		end
		$display("test rw done");
	endtask : t_rw

	task automatic t_part;
		acc(1'b1, BANK_BASE + 32'h1, SIZ_BYTE, 32'h0);
		check(32'({ak, te}), 32'h1);
		acc(1'b1, BANK_BASE + 32'h2, SIZ_HALF, 32'h0);
		check(32'({ak, te}), 32'h1);
		check(ctrl, 32'ha55a3cc3);
		lcal_core_model_i.rmw(BANK_BASE, 2'h2, 8'h77);
		check(ctrl, 32'ha55a77c3);
		$display("test partial done");
	endtask : t_part

	task automatic t_flags;
		status_i = 8'h5a;
		event_i = 8'h04;
		@(negedge ref_clk_i);
		event_i = 8'h00;
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'hff0000ff);
		check(32'(flags), 32'h04);
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h00300000);
		check(32'(flags), 32'h34);
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h00000400);
		check(32'(flags), 32'h30);
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h0);
		acc(1'b0, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h0);
		check(rd, 32'h5a000030);
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h00ff0000);
		check(32'(flags), 32'hff);
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h0000ff00);
		check(32'(flags), 32'h00);
		event_i = 8'h01;
		acc(1'b1, BANK_BASE + OFF_FLAG, SIZ_WORD, 32'h0000ff00);
		event_i = 8'h00;
		check(32'(flags), 32'h01);
		$display("test flags done");
	endtask : t_flags

	task automatic t_action;
		acc(1'b1, BANK_BASE + OFF_ACT, SIZ_WORD, 32'h03);
		check(32'(action), 32'h03);
		action_done_i = 8'h01;
		@(negedge ref_clk_i);
		action_done_i = 8'h00;
		acc(1'b0, BANK_BASE + OFF_ACT, SIZ_WORD, 32'h0);
		check(rd, 32'h02);
		acc(1'b1, BANK_BASE + OFF_ACT, SIZ_WORD, 32'h100);
		check(32'(lrst), 32'h1);
		@(negedge ref_clk_i);
		check(32'(lrst), 32'h0);
		check(ctrl, 32'ha50477c3);
		check(32'({flags, action}), 32'h0);
		$display("test action done");
	endtask : t_action

	task automatic t_resets;
		acc(1'b1, BANK_BASE, SIZ_WORD, 32'h5affffff);
		sys_reset_i = 1'b1;
		@(negedge ref_clk_i);
		sys_reset_i = 1'b0;
		check(ctrl, 32'h5a0402ff);
		acc(1'b1, BANK_BASE, SIZ_WORD, 32'h5affffff);
		local_reset_i = 1'b1;
		#1 check(32'(lrst), 32'h1);
		@(negedge ref_clk_i);
		local_reset_i = 1'b0;
		check(ctrl, 32'h5a04ffff);
		acc(1'b1, BANK_BASE, SIZ_WORD, 32'h5affffff);
		watchdog_i = 1'b1;
		@(negedge ref_clk_i);
		watchdog_i = 1'b0;
		check(ctrl, 32'h5a04ffff);
		rst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'b0;
		check(ctrl, 32'h5a040201);
		acc(1'b0, BANK_BASE, SIZ_WORD, 32'h0);
		check(rd, 32'h5a040201);
		$display("test resets done");
	endtask : t_resets

	initial begin
		// six cycles of power-up reset before any traffic
		repeat (6) @(negedge ref_clk_i);
		rst_i = 1'b0;
		t_map();
		t_rw();
		t_part();
		t_flags();
		t_action();
		t_resets();
		summarize();
	end
endmodule : lcal_local_ctrl_status_bank_tb_top

/* hdl/lcal_dec_if.sv */
`timescale 1ns/10ps
interface lcal_dec_if;
	logic        req;
	logic        wr;
	logic [31:0] addr;
	logic [1:0]  siz;
	logic        hit;
	logic        full;
	logic [2:0]  sel;
	logic [31:0] lanes;

	modport dec  (input req, wr, addr, siz, output hit, full, sel, lanes);
	modport core (output req, wr, addr, siz, input hit, full, sel, lanes);
endinterface : lcal_dec_if

/* hdl/lcal_decode.sv */
`timescale 1ns/10ps
module lcal_decode
	import lcal_pkg::*;
(
	lcal_dec_if.dec dif
);

	localparam logic [7:0] REG_OFF [NUM_REGS] = '{OFF_CTRL, OFF_FLAG, OFF_ACT};

	// big-endian lanes: offset 0 sits on the top byte
	function automatic logic [31:0] lane_mask(input logic [1:0] siz, input logic [1:0] a);
		logic [31:0] m;
		m = 32'hffffffff;
		if (siz == SIZ_BYTE) begin
			m = 32'hff000000 >> {a, 3'h0};
		end else if (siz == SIZ_HALF) begin
			m = a[1] ? 32'h0000ffff : 32'hffff0000;
		end
		return m;
	endfunction : lane_mask

	assign dif.hit   = dif.req && ((dif.addr & BANK_WIN_MASK) == BANK_BASE);
	assign dif.full  = (dif.siz == SIZ_WORD) || (dif.siz == SIZ_LINE);
	assign dif.lanes = lane_mask(dif.siz, dif.addr[1:0]);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_sel
			assign dif.sel[gi] = dif.hit && (dif.addr[7:2] == REG_OFF[gi][7:2]);
		end
	endgenerate

endmodule : lcal_decode

/* hdl/lcal_local_ctrl_status_bank.sv */
`timescale 1ns/10ps
// Overview of operation
// - the bank answers only inside a window at base fff40000 and every register is 32 bits wide.
// - byte, half and full word reads complete normally with the addressed lanes of the register.
// - a byte or half word write ends with transfer_error_ack and leaves the register unchanged.
// - read-only status bits ignore writes and show only internally produced state.
// - read/write bits keep what was written and return it on later reads.
// - self-clearing bits are set by a write, drop once their action is taken, and read meanwhile.
// - writing one to a clear bit clears its associated bit, zero does nothing, it reads zero.
// - writing one to a set bit sets its associated bit, zero does nothing, it reads zero.
// - power-up class bits return to default on power-up reset.
// - system class bits return to default on the backplane system reset.
// - local class bits return to default on a local reset.
// - reset-immune bits keep their value through every reset.
// - local reset comes from its input, watchdog, system reset or a control bit; power-up resets local class bits through rst_i only.
module lcal_local_ctrl_status_bank
	import lcal_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        sys_reset_i,
	input  wire logic        local_reset_i,
	input  wire logic        watchdog_i,
	input  wire logic        req_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [1:0]  siz_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [7:0]  status_i,
	input  wire logic [7:0]  event_i,
	input  wire logic [7:0]  action_done_i,
	output logic      [31:0] rdata_o,
	output logic             ack_o,
	output logic             transfer_error_ack_o,
	output logic      [31:0] ctrl_o,
	output logic      [7:0]  flags_o,
	output logic      [7:0]  action_o,
	output logic             local_reset_o
);

	// ****************************************************************
	// decode
	// ****************************************************************
	lcal_dec_if dif ();

	assign dif.req  = req_i;
	assign dif.wr   = wr_i;
	assign dif.addr = addr_i;
	assign dif.siz  = siz_i;

	lcal_decode u_decode (
		.dif (dif)
	);

	logic        wr_ok;
	logic        wr_bad;
	logic        rd_ok;
	logic        w_ctrl;
	logic        w_flag;
	logic        w_act;
	logic        loc_rst;
	logic [7:0]  clr_bits;
	logic [7:0]  set_bits;
	logic [31:0] rd_word;

	assign wr_ok   = dif.hit && wr_i && dif.full;
	assign wr_bad  = dif.hit && wr_i && !dif.full;
	assign rd_ok   = dif.hit && !wr_i;
	assign w_ctrl  = wr_ok && dif.sel[0];
	assign w_flag  = wr_ok && dif.sel[1];
	assign w_act   = wr_ok && dif.sel[2];

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [7:0]  ctrl_p_reg, ctrl_p_next;
	logic [7:0]  ctrl_s_reg, ctrl_s_next;
	logic [7:0]  ctrl_l_reg, ctrl_l_next;
	logic [7:0]  ctrl_x_reg, ctrl_x_next;
	logic [7:0]  flag_reg, flag_next;
	logic [7:0]  act_reg, act_next;
	logic        lrst_req_reg, lrst_req_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        ack_reg, ack_next;
	logic        tea_reg, tea_next;

	// power-up also reaches local class bits through rst_i itself
	assign loc_rst = local_reset_i || sys_reset_i || watchdog_i || lrst_req_reg;

	assign clr_bits = w_flag ? wdata_i[FLAG_CLR_LSB +: 8] : 8'h00;
	assign set_bits = w_flag ? wdata_i[FLAG_SET_LSB +: 8] : 8'h00;

	assign ctrl_p_next = w_ctrl ? wdata_i[CTRL_P_LSB +: 8] : ctrl_p_reg;
	assign ctrl_s_next = sys_reset_i ? CTRL_S_RST :
		(w_ctrl ? wdata_i[CTRL_S_LSB +: 8] : ctrl_s_reg);
	assign ctrl_l_next = loc_rst ? CTRL_L_RST :
		(w_ctrl ? wdata_i[CTRL_L_LSB +: 8] : ctrl_l_reg);
	assign ctrl_x_next = w_ctrl ? wdata_i[CTRL_X_LSB +: 8] : ctrl_x_reg;

	// a hardware event in the clearing cycle survives the clear
	assign flag_next = loc_rst ? FLAG_RST :
		((flag_reg & ~clr_bits) | set_bits | event_i);

	// a new write wins over a done in the same cycle, so no request is lost
	assign act_next = loc_rst ? ACT_RST :
		((act_reg & ~action_done_i) | (w_act ? wdata_i[ACT_LSB +: 8] : 8'h00));

	// the request bit follows the write strobe alone, so it lives one cycle
	assign lrst_req_next = w_act && wdata_i[LRST_REQ_BIT];

	// clear and set fields always read back as zero
	assign rd_word = dif.sel[0] ? {ctrl_x_reg, ctrl_l_reg, ctrl_s_reg, ctrl_p_reg} :
		dif.sel[1] ? {status_i, 8'h00, 8'h00, flag_reg} :
		dif.sel[2] ? {23'h000000, lrst_req_reg, act_reg} : 32'h00000000;

	assign rdata_next = rd_ok ? (rd_word & dif.lanes) : rdata_reg;
	assign ack_next   = dif.hit && !wr_bad;
	assign tea_next   = wr_bad;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_p_reg   <= CTRL_P_RST;
			ctrl_s_reg   <= CTRL_S_RST;
			ctrl_l_reg   <= CTRL_L_RST;
			flag_reg     <= FLAG_RST;
			act_reg      <= ACT_RST;
			lrst_req_reg <= 1'b0;
			rdata_reg    <= 32'h00000000;
			ack_reg      <= 1'b0;
			tea_reg      <= 1'b0;
		end else begin
			ctrl_p_reg   <= ctrl_p_next;
			ctrl_s_reg   <= ctrl_s_next;
			ctrl_l_reg   <= ctrl_l_next;
			flag_reg     <= flag_next;
			act_reg      <= act_next;
			lrst_req_reg <= lrst_req_next;
			rdata_reg    <= rdata_next;
			ack_reg      <= ack_next;
			tea_reg      <= tea_next;
		end
	end

	// no reset at all: these survive power-up too, so they start unknown
	always_ff @(posedge ref_clk_i) begin
		ctrl_x_reg <= ctrl_x_next;
	end

	assign rdata_o              = rdata_reg;
	assign ack_o                = ack_reg;
	assign transfer_error_ack_o = tea_reg;
	assign ctrl_o               = {ctrl_x_reg, ctrl_l_reg, ctrl_s_reg, ctrl_p_reg};
	assign flags_o              = flag_reg;
	assign action_o             = act_reg;
	assign local_reset_o        = loc_rst;

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_full_wr_ctrl;
		req_i && w_ctrl;
	endsequence

	sequence s_full_wr_flag;
		req_i && w_flag && !loc_rst;
	endsequence

	sequence s_act_taken;
		action_o[0] && action_done_i[0] && !(w_act && wdata_i[0]) && !loc_rst;
	endsequence

	property p_no_resp_outside;
		@(posedge ref_clk_i) disable iff (rst_i)
		req_i && !dif.hit |=> !ack_o && !transfer_error_ack_o;
	endproperty
	a_no_resp_outside: assert property (p_no_resp_outside) else $error("answer outside bank");

	property p_read_ack;
		@(posedge ref_clk_i) disable iff (rst_i)
		rd_ok |=> ack_o && !transfer_error_ack_o && rdata_o == ($past(rd_word) & $past(dif.lanes));
	endproperty
	a_read_ack: assert property (p_read_ack) else $error("read not answered");

	property p_partial_tea;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_bad |=> transfer_error_ack_o && !ack_o;
	endproperty
	a_partial_tea: assert property (p_partial_tea) else $error("partial write not refused");

	property p_partial_keep;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_bad && !loc_rst |=> ctrl_o[23:0] == $past(ctrl_o[23:0]) && flags_o == ($past(flags_o) | $past(event_i));
	endproperty
	a_partial_keep: assert property (p_partial_keep) else $error("partial write changed bank");

	property p_status_ro;
		@(posedge ref_clk_i) disable iff (rst_i)
		rd_ok && dif.sel[1] && dif.full |=> rdata_o[31:24] == $past(status_i) && rdata_o[23:8] == 16'h0000;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status or clear-set lanes wrong");

	property p_rw_store;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_full_wr_ctrl ##0 !loc_rst |=> ctrl_o == $past(wdata_i);
	endproperty
	a_rw_store: assert property (p_rw_store) else $error("control word not stored");

	property p_selfclr;
		@(posedge ref_clk_i) disable iff (rst_i)
		(w_act && wdata_i[0] && !loc_rst) ##1 s_act_taken |=> !action_o[0];
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("action bit not self-cleared");

	property p_flag_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_full_wr_flag ##0 (wdata_i[23:8] == 16'h00ff && event_i == 8'h00) |=> flags_o == 8'h00;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("clear write failed");

	property p_event_wins;
		@(posedge ref_clk_i) disable iff (rst_i)
		event_i[0] && !loc_rst |=> flags_o[0];
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("event lost");

	property p_flag_set;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_full_wr_flag ##0 wdata_i[23:16] == 8'hff |=> flags_o == 8'hff;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("set write failed");

	property p_sys_reset;
		@(posedge ref_clk_i) disable iff (rst_i)
		sys_reset_i |=> ctrl_o[15:8] == CTRL_S_RST && ctrl_o[23:16] == CTRL_L_RST;
	endproperty
	a_sys_reset: assert property (p_sys_reset) else $error("system class not reset");

	property p_local_reset;
		@(posedge ref_clk_i) disable iff (rst_i)
		(local_reset_i || watchdog_i) && !w_ctrl |=> ctrl_o[23:16] == CTRL_L_RST
			&& flags_o == FLAG_RST && ctrl_o[7:0] == $past(ctrl_o[7:0]);
	endproperty
	a_local_reset: assert property (p_local_reset) else $error("local class wrong");

	property p_lrst_req;
		@(posedge ref_clk_i) disable iff (rst_i)
		w_act && wdata_i[LRST_REQ_BIT] |=> local_reset_o ##1 action_o == ACT_RST;
	endproperty
	a_lrst_req: assert property (p_lrst_req) else $error("control bit reset missing");

endmodule : lcal_local_ctrl_status_bank

/* hdl/lcal_pkg.sv */
package lcal_pkg;

	// ****************************************************************
	// address map
	// ****************************************************************
	localparam logic [31:0] BANK_BASE      = 32'hfff40000;
	localparam logic [31:0] BANK_WIN_MASK  = 32'hffffff00;
	localparam int          NUM_REGS       = 3;
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_FLAG       = 8'h04;
	localparam logic [7:0]  OFF_ACT        = 8'h08;

	// ****************************************************************
	// transfer size codes
	// ****************************************************************
	localparam logic [1:0]  SIZ_WORD       = 2'h0;
	localparam logic [1:0]  SIZ_BYTE       = 2'h1;
	localparam logic [1:0]  SIZ_HALF       = 2'h2;
	localparam logic [1:0]  SIZ_LINE       = 2'h3;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int          CTRL_P_LSB     = 0;
	localparam int          CTRL_S_LSB     = 8;
	localparam int          CTRL_L_LSB     = 16;
	localparam int          CTRL_X_LSB     = 24;
	localparam int          FLAG_LSB       = 0;
	localparam int          FLAG_CLR_LSB   = 8;
	localparam int          FLAG_SET_LSB   = 16;
	localparam int          STAT_LSB       = 24;
	localparam int          ACT_LSB        = 0;
	localparam int          LRST_REQ_BIT   = 8;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0]  CTRL_P_RST     = 8'h01;
	localparam logic [7:0]  CTRL_S_RST     = 8'h02;
	localparam logic [7:0]  CTRL_L_RST     = 8'h04;
	localparam logic [7:0]  FLAG_RST       = 8'h00;
	localparam logic [7:0]  ACT_RST        = 8'h00;

endpackage : lcal_pkg
